/* shared/hdsp_pkg.sv */
package hdsp_pkg;
	// register byte offsets on the APB bus
	localparam logic [7:0] ADDR_OFS = 8'h00;
	localparam logic [7:0] CFG_OFS = 8'h04;
	localparam logic [7:0] DLY_OFS = 8'h08;
	localparam logic [7:0] STAT_OFS = 8'h0C;
	// field positions
	localparam int UNIT_LSB = 0;
	localparam int GROUP_LSB = 8;
	localparam int MODE_LSB = 0;
	localparam int BAUD_LSB = 4;
	localparam int ST_LSB = 0;
	localparam int DRV_LSB = 2;
	localparam int GRPADR_LSB = 3;
	localparam int EUNIT_LSB = 8;
	localparam int EGROUP_LSB = 16;
	localparam int EBAUD_LSB = 24;
	// reset values and limits
	localparam logic [4:0] GROUP_RST = 5'h01;
	localparam logic [2:0] UNIT_RST = 3'h1;
	localparam logic [1:0] BAUD_RST = 2'h1;
	localparam logic [7:0] DLY_RST = 8'h14;
	localparam logic [4:0] GROUP_MAX = 5'h18;
	localparam logic [7:0] DLY_MAX = 8'hFA;
	// fixed fieldbus node address (1.1 = 11) and rate code (19.2k)
	localparam logic [4:0] FBUS_GROUP = 5'h01;
	localparam logic [2:0] FBUS_UNIT = 3'h1;
	localparam logic [1:0] FBUS_BAUD = 2'h3;
	// timing in its own units
	localparam int unsigned HOLD_US = 1500;
	localparam int unsigned US_PER_MS = 1000;
	localparam int unsigned BAUD0_HZ = 2400;
	localparam int unsigned BAUD1_HZ = 4800;
	localparam int unsigned BAUD2_HZ = 9600;
	localparam int unsigned BAUD3_HZ = 19200;
	// protocol mode codes
	typedef enum logic [1:0] {
		HDSP_ANSI = 2'h0,
		HDSP_RTU = 2'h1,
		HDSP_FBUS = 2'h2
	} hdsp_mode_t;
	// line turnaround states
	typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_TX, ST_HOLD} hdsp_st_t;
	// effective link settings handed to the serial engine
	typedef struct packed {
		logic [4:0] group;
		logic [2:0] unit;
		logic [1:0] baud;
		hdsp_mode_t mode;
	} hdsp_eff_t;
endpackage

/* rtl/hdsp_core.sv */
`timescale 1ns/1ps
module hdsp_core #(
	parameter int unsigned CLK_HZ = 125000000
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic rxMsgEnd,
	input wire logic txLastChar,
	output logic txDriveEn,
	output logic baudTick,
	output hdsp_pkg::hdsp_eff_t effCfg,
	output logic groupAddr
);
	// derived cycle counts
	localparam int unsigned MS_CYC_I = CLK_HZ / 1000;
	localparam int unsigned HOLD_CYC_I =
		MS_CYC_I * hdsp_pkg::HOLD_US / hdsp_pkg::US_PER_MS;
	localparam logic [23:0] MS_CYC = 24'((MS_CYC_I < 1) ? 1 : MS_CYC_I);
	localparam logic [23:0] HOLD_CYC =
		24'((HOLD_CYC_I < 1) ? 1 : HOLD_CYC_I);
	localparam logic [23:0] DIV0 = 24'(CLK_HZ / hdsp_pkg::BAUD0_HZ);
	localparam logic [23:0] DIV1 = 24'(CLK_HZ / hdsp_pkg::BAUD1_HZ);
	localparam logic [23:0] DIV2 = 24'(CLK_HZ / hdsp_pkg::BAUD2_HZ);
	localparam logic [23:0] DIV3 = 24'(CLK_HZ / hdsp_pkg::BAUD3_HZ);

	// whole state of the block
	typedef struct packed {
		hdsp_pkg::hdsp_st_t st;
		logic [4:0] group;
		logic [2:0] unit;
		hdsp_pkg::hdsp_mode_t mode;
		logic [1:0] baud;
		logic [7:0] dly;
		logic [23:0] msCnt;
		logic [7:0] waitMs;
		logic [23:0] holdCnt;
		logic [23:0] baudCnt;
		logic tick;
		logic drv;
		logic rdy;
		logic err;
		logic [31:0] rdata;
	} hdsp_state_t;

	hdsp_state_t s_q; // registered state
	hdsp_state_t s_d; // next state
	hdsp_pkg::hdsp_eff_t eff; // effective settings
	logic [23:0] curDiv; // active baud divider
	logic access; // access phase, second cycle
	logic fbus; // fieldbus mode active

	// effective address and rate, fieldbus overrides config
	always_comb begin
		fbus = (s_q.mode == hdsp_pkg::HDSP_FBUS);
		eff.mode = s_q.mode;
		eff.group = fbus ? hdsp_pkg::FBUS_GROUP : s_q.group;
		eff.unit = fbus ? hdsp_pkg::FBUS_UNIT : s_q.unit;
		eff.baud = fbus ? hdsp_pkg::FBUS_BAUD : s_q.baud;
		// baud code to clock divider
		case (eff.baud)
			2'h0: curDiv = DIV0;
			2'h1: curDiv = DIV1;
			2'h2: curDiv = DIV2;
			default: curDiv = DIV3;
		endcase
	end

	assign access = psel && penable && s_q.rdy;

	// next-state logic: bus slave, baud divider, turnaround
	always_comb begin
		s_d = s_q;
		s_d.tick = 1'b0;
		// one wait state, then answer with registered data
		s_d.rdy = psel && penable && !s_q.rdy;
		if (psel && penable && !s_q.rdy) begin
			s_d.err = 1'b0;
			s_d.rdata = '0;
			case (paddr)
				hdsp_pkg::ADDR_OFS: begin
					s_d.rdata[hdsp_pkg::GROUP_LSB +: 5] = s_q.group;
					s_d.rdata[hdsp_pkg::UNIT_LSB +: 3] = s_q.unit;
				end
				hdsp_pkg::CFG_OFS: begin
					s_d.rdata[hdsp_pkg::MODE_LSB +: 2] = s_q.mode;
					s_d.rdata[hdsp_pkg::BAUD_LSB +: 2] = s_q.baud;
				end
				hdsp_pkg::DLY_OFS: s_d.rdata[7:0] = s_q.dly;
				hdsp_pkg::STAT_OFS: begin
					s_d.rdata[hdsp_pkg::ST_LSB +: 2] = s_q.st;
					s_d.rdata[hdsp_pkg::DRV_LSB] = s_q.drv;
					s_d.rdata[hdsp_pkg::GRPADR_LSB] = groupAddr;
					s_d.rdata[hdsp_pkg::EUNIT_LSB +: 3] = eff.unit;
					s_d.rdata[hdsp_pkg::EGROUP_LSB +: 5] = eff.group;
					s_d.rdata[hdsp_pkg::EBAUD_LSB +: 2] = eff.baud;
				end
				default: s_d.err = 1'b1; // unmapped address
			endcase
		end
		// writes take effect at the edge that completes the access
		if (access && pwrite) begin
			case (paddr)
				hdsp_pkg::ADDR_OFS: begin
					// out-of-range group is refused whole
					if (pwdata[hdsp_pkg::GROUP_LSB +: 5] <= hdsp_pkg::GROUP_MAX)
					begin
						s_d.group = pwdata[hdsp_pkg::GROUP_LSB +: 5];
						s_d.unit = pwdata[hdsp_pkg::UNIT_LSB +: 3];
					end
				end
				hdsp_pkg::CFG_OFS: begin
					// reserved mode code 3 keeps the old mode
					if (pwdata[hdsp_pkg::MODE_LSB +: 2] != 2'h3)
						s_d.mode = hdsp_pkg::hdsp_mode_t'(
							pwdata[hdsp_pkg::MODE_LSB +: 2]);
					s_d.baud = pwdata[hdsp_pkg::BAUD_LSB +: 2];
				end
				hdsp_pkg::DLY_OFS: begin
					if (pwdata[7:0] <= hdsp_pkg::DLY_MAX)
						s_d.dly = pwdata[7:0];
				end
				default: ;
			endcase
		end
		// free-running bit-rate divider
		if (s_q.baudCnt >= curDiv - 24'h000001) begin
			s_d.baudCnt = '0;
			s_d.tick = 1'b1;
		end else begin
			s_d.baudCnt = s_q.baudCnt + 24'h000001;
		end
		// line turnaround sequence
		case (s_q.st)
			hdsp_pkg::ST_IDLE: begin
				// host owns the line; wait for its message to end
				if (rxMsgEnd) begin
					s_d.st = hdsp_pkg::ST_WAIT;
					s_d.msCnt = '0;
					s_d.waitMs = '0;
				end
			end
			hdsp_pkg::ST_WAIT: begin
				// ANSI waits the programmed delay, others go at once
				if (s_q.mode != hdsp_pkg::HDSP_ANSI ||
					s_q.waitMs >= s_q.dly) begin
					s_d.st = hdsp_pkg::ST_TX;
				end else if (s_q.msCnt == MS_CYC - 24'h000001) begin
					s_d.msCnt = '0;
					s_d.waitMs = s_q.waitMs + 8'h01;
				end else begin
					s_d.msCnt = s_q.msCnt + 24'h000001;
				end
			end
			hdsp_pkg::ST_TX: begin
				// drivers on until the engine flags its last character
				if (txLastChar) begin
					s_d.st = hdsp_pkg::ST_HOLD;
					s_d.holdCnt = '0;
				end
			end
			hdsp_pkg::ST_HOLD: begin
				// keep driving a fixed 1.5 ms, then free the line
				if (s_q.holdCnt == HOLD_CYC - 24'h000001)
					s_d.st = hdsp_pkg::ST_IDLE;
				else
					s_d.holdCnt = s_q.holdCnt + 24'h000001;
			end
			default: s_d.st = hdsp_pkg::ST_IDLE;
		endcase
		// drivers only while this end owns the line
		s_d.drv = (s_d.st == hdsp_pkg::ST_TX) ||
			(s_d.st == hdsp_pkg::ST_HOLD);
	end

	// state register
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			s_q <= '0;
			s_q.st <= hdsp_pkg::ST_IDLE;
			s_q.group <= hdsp_pkg::GROUP_RST;
			s_q.unit <= hdsp_pkg::UNIT_RST;
			s_q.mode <= hdsp_pkg::HDSP_ANSI;
			s_q.baud <= hdsp_pkg::BAUD_RST;
			s_q.dly <= hdsp_pkg::DLY_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs
	assign prdata = s_q.rdata;
	assign pready = s_q.rdy;
	assign pslverr = s_q.rdy && s_q.err;
	assign txDriveEn = s_q.drv;
	assign baudTick = s_q.tick;
	assign effCfg = eff;
	// flags a group (broadcast) address on this node
	assign groupAddr = (eff.group == 5'h00) || (eff.unit == 3'h0);

	// checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	property p_group_range;
		s_q.group <= hdsp_pkg::GROUP_MAX;
	endproperty
	a_group_range: assert property (p_group_range)
		else $error("group address out of range");

	property p_mode_legal;
		s_q.mode != 2'h3 && $past(s_q.mode) != 2'h3;
	endproperty
	a_mode_legal: assert property (p_mode_legal)
		else $error("reserved mode code stored");

	property p_fbus_fixed;
		fbus |-> effCfg.group == hdsp_pkg::FBUS_GROUP &&
			effCfg.unit == hdsp_pkg::FBUS_UNIT && curDiv == DIV3;
	endproperty
	a_fbus_fixed: assert property (p_fbus_fixed)
		else $error("fieldbus settings not forced");

	// the tick right after a divider change ends a carried-over count
	property p_baud_period;
		baudTick && $stable(curDiv) && $past(curDiv, 2) == curDiv |->
			$past(s_q.baudCnt) == curDiv - 1;
	endproperty
	a_baud_period: assert property (p_baud_period)
		else $error("bit tick period wrong");

	property p_ansi_delay;
		$rose(txDriveEn) && s_q.mode == hdsp_pkg::HDSP_ANSI |->
			$past(s_q.waitMs) >= s_q.dly;
	endproperty
	a_ansi_delay: assert property (p_ansi_delay)
		else $error("drivers enabled before delay");

	property p_half_duplex;
		s_q.st == hdsp_pkg::ST_IDLE && rxMsgEnd |-> !txDriveEn [*2];
	endproperty
	a_half_duplex: assert property (p_half_duplex)
		else $error("drivers on while host owns line");

	property p_hold_len;
		$fell(txDriveEn) |-> $past(s_q.st) == hdsp_pkg::ST_HOLD &&
			$past(s_q.holdCnt) == HOLD_CYC - 1;
	endproperty
	a_hold_len: assert property (p_hold_len)
		else $error("hold time wrong");

	property p_other_go;
		s_q.st == hdsp_pkg::ST_WAIT && s_q.mode != hdsp_pkg::HDSP_ANSI
			|=> txDriveEn;
	endproperty
	a_other_go: assert property (p_other_go)
		else $error("non-ANSI reply not released");

	property p_apb_wait;
		psel && penable && !pready |=> pready;
	endproperty
	a_apb_wait: assert property (p_apb_wait)
		else $error("bus answer late");

	c_fbus: cover property (s_q.mode == hdsp_pkg::HDSP_FBUS);
	c_turn: cover property ($fell(txDriveEn));
	c_cfgwr: cover property (access && pwrite && paddr == hdsp_pkg::CFG_OFS);
endmodule

/* test/hdsp_host_model.sv */
`timescale 1ns/1ps
module hdsp_host_model #(
	parameter int HOLD = 144
) (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic go,
	input wire logic txDriveEn,
	output logic rxMsgEnd,
	output logic hostDrv
);
	// cycles since the device released the line, saturating
	int quiet;
	// characters still to send in the current host message
	int sendLeft;
	// host sends a short message, then turns the line round
	always @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			quiet <= HOLD;
			sendLeft <= 0;
			rxMsgEnd <= 1'b0;
			hostDrv <= 1'b0;
		end else begin
			// hold window restarts while the device drives
			quiet <= txDriveEn ? 0 : (quiet < HOLD ? quiet + 1 : quiet);
			rxMsgEnd <= (sendLeft == 1);
			// drivers dropped as the last character ends
			hostDrv <= (sendLeft > 1);
			if (sendLeft > 0) begin
				sendLeft <= sendLeft - 1;
			end else if (go && quiet >= HOLD && !txDriveEn) begin
				// new message only once the hold has elapsed
				sendLeft <= 8;
			end
		end
	end
endmodule

/* test/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
	localparam logic [7:0] AD = hdsp_pkg::ADDR_OFS;
	localparam logic [7:0] CF = hdsp_pkg::CFG_OFS;
	localparam logic [7:0] DL = hdsp_pkg::DLY_OFS;
	// stimulus and observed design signals
	logic mclk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
	logic [7:0] paddr = 8'h00, d;
	logic [31:0] pwdata = 32'h00000000, prdata, rd;
	logic pready, pslverr, err, txLastChar = 0, txDriveEn, baudTick;
	logic rxMsgEnd, groupAddr, hostDrv, go = 0;
	logic [4:0] g;
	logic [2:0] u;
	hdsp_pkg::hdsp_eff_t effCfg;
	int num_errors = 0, tests_run = 0, cyc = 0, n;
	logic [15:0] lfsr = 16'h692A;
	always #4 mclk = ~mclk;
	hdsp_core #(.CLK_HZ(96000)) dut(.mclk(mclk), .rst_n(rst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rxMsgEnd(rxMsgEnd), .txLastChar(txLastChar),
		.txDriveEn(txDriveEn), .baudTick(baudTick), .effCfg(effCfg),
		.groupAddr(groupAddr));
	hdsp_host_model #(.HOLD(144)) host(.mclk(mclk), .rst_n(rst_n),
		.go(go), .txDriveEn(txDriveEn), .rxMsgEnd(rxMsgEnd),
		.hostDrv(hostDrv));
	// next pseudo-random state
	function logic [15:0] nxt(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	// expected address and config words
	function logic [31:0] adw(input logic [4:0] gg, input logic [2:0] uu);
		return {19'h00000, gg, 5'h00, uu};
	endfunction
	function logic [31:0] cfw(input logic [1:0] b, input logic [1:0] m);
		return {26'h0000000, b, 2'h0, m};
	endfunction
	// tick period in cycles for a baud code
	function int per(input int b);
		return 96000 / (2400 << b);
	endfunction
	// compare and count
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] ex);
		tests_run++;
		if (seen !== ex) begin
			num_errors++;
			$display("MISMATCH %s expected %h seen %h", nm, ex, seen);
		end
	endtask
	// one APB transfer, held until pready
	task apb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge mclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge mclk);
		penable <= 1'b1;
		n = 0;
		do begin @(posedge mclk); n++; end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task rdchk(input string nm, input logic [7:0] a, input logic [31:0] ex);
		apb(1'b0, a, 32'h00000000);
		chk(nm, rd, ex);
	endtask
	// measure baud tick spacing once it has settled
	task tick(input int ex);
		repeat (3) begin
			n = 0;
			do begin @(posedge mclk); n++; end
			while (baudTick !== 1'b1 && n < 100);
		end
		chk("tick", n, ex);
	endtask
	// host message, device reply, then line release
	task turn(input int ex);
		go <= 1'b1;
		n = 0;
		do begin @(posedge mclk); #1; n++; end
		while (rxMsgEnd !== 1'b1 && n < 500);
		go <= 1'b0;
		n = 0;
		do begin @(posedge mclk); #1; n++; end
		while (txDriveEn !== 1'b1 && n < 1000);
		chk("rise", n, ex);
		@(posedge mclk);
		txLastChar <= 1'b1;
		@(posedge mclk);
		txLastChar <= 1'b0;
		n = 0;
		do begin @(posedge mclk); #1; n++; end
		while (txDriveEn !== 1'b0 && n < 500);
		chk("fall", n, 144);
	endtask
	task test_done();
		$display("checks %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// line watch and hang guard
	always @(posedge mclk) begin
		cyc++;
		if (hostDrv === 1'b1 && txDriveEn === 1'b1) chk("duplex", 1, 0);
		if (cyc == 30000) begin
			chk("timeout", 0, 1);
			test_done();
		end
	end
	// main sequence
	initial begin
		repeat (2) @(posedge mclk);
		rst_n <= 1'b1;
		rdchk("addr", AD, adw(5'h01, 3'h1));
		rdchk("cfg", CF, cfw(2'h1, 2'h0));
		rdchk("dly", DL, 32'h00000014);
		apb(1'b0, 8'h40, 32'h00000000);
		chk("slverr", err, 1);
		$display("test reset done");
		apb(1'b1, AD, adw(5'h18, 3'h7));
		apb(1'b1, AD, adw(5'h19, 3'h3));
		rdchk("addrmax", AD, adw(5'h18, 3'h7));
		apb(1'b1, AD, adw(5'h03, 3'h0));
		@(posedge mclk);
		chk("grpaddr", groupAddr, 1);
		repeat (4) begin
			lfsr = nxt(lfsr);
			// unit addresses keep clear of zero digits
			g = 5'(lfsr[4:0] % 24 + 1);
			u = 3'(lfsr[7:5] % 7 + 1);
			apb(1'b1, AD, adw(g, u));
			rdchk("addrrnd", AD, adw(g, u));
			chk("effaddr", {effCfg.group, effCfg.unit}, {g, u});
		end
		$display("test address done");
		for (int b = 0; b < 4; b++) begin
			apb(1'b1, CF, cfw(2'(b), 2'h0));
			tick(per(b));
		end
		apb(1'b1, CF, cfw(2'h0, 2'h2));
		// let the write land before looking at the settings
		@(posedge mclk);
		chk("fbus", effCfg, {5'h01, 3'h1, 2'h3, 2'h2});
		rdchk("stat", hdsp_pkg::STAT_OFS, 32'h03010100);
		tick(per(3));
		apb(1'b1, CF, cfw(2'h1, 2'h3));
		rdchk("mode3", CF, cfw(2'h1, 2'h2));
		apb(1'b1, CF, cfw(2'h2, 2'h1));
		@(posedge mclk);
		chk("rtu", effCfg, {g, u, 2'h2, 2'h1});
		apb(1'b1, DL, 32'h00000003);
		turn(2);
		$display("test modes done");
		apb(1'b1, CF, cfw(2'h3, 2'h0));
		apb(1'b1, DL, 32'h00000000);
		turn(2);
		lfsr = nxt(lfsr);
		d = 8'(lfsr[1:0] + 1);
		apb(1'b1, DL, {24'h000000, d});
		apb(1'b1, DL, 32'h000000FB);
		rdchk("dlymax", DL, {24'h000000, d});
		turn(d * 96 + 2);
		$display("test turnaround done");
		test_done();
	end
endmodule
